// ===== rtl/gamma_dac_consts.svh
// constants for the gamma/common-voltage register access block
`ifndef GAMMA_DAC_CONSTS_SVH
`define GAMMA_DAC_CONSTS_SVH
`define DEV_ADDR_HI      6'h2c
`define GCALL_ADDR       8'h00
`define GCALL_RESET      8'h06
`define PTR_LAST_CHAN    6'h17
`define PTR_GAMMA_LAST   6'h0f
`define PTR_COM_FIRST    6'h12
`define PTR_COM_SECOND   6'h13
`define PTR_REVISION     6'h3c
`define PTR_IDENTITY     6'h3d
`define PTR_WRITE_COUNT  6'h3f
`define CMD_PLAIN        2'h0
`define CMD_GEN_ACQ      2'h2
`define CMD_ONE_ACQ      2'h1
`define DATA_NV_MARK     2'h1
`define DEFAULT_CODE     10'h200
`define IDENTITY_CODE    16'h5a3c // arbitrary value, names no real part
`define REVISION_CODE    16'h0001
`define NUM_CHAN         18
`define NV_WRITE_SAT     5'h10
`define CLK_MHZ          100
`define NV_PROG_TIME_US  250
`define NV_PROG_CYCLES   (`NV_PROG_TIME_US * `CLK_MHZ)
`endif

// ===== rtl/gamma_dac_pkg.sv
// types for the gamma/common-voltage register access block
package gamma_dac_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_ACK  = 3'h3,
    ST_TX   = 3'h2,
    ST_RACK = 3'h6
  } link_state_t;
  typedef enum logic [1:0] {PH_ADDR = 2'h0, PH_PTR = 2'h1, PH_DHI = 2'h3, PH_DLO = 2'h2} phase_t;
  typedef logic [17:0][9:0] chan_bank_t;
  typedef logic [17:0][14:0] nv_bank_t;
  typedef struct packed {
    logic       ok;
    logic [9:0] data;
  } ecc_result_t;
  typedef struct packed {
    logic        sclMeta, sclSync, sclPrev;
    logic        sdaMeta, sdaSync, sdaPrev;
    logic        selMeta, selSync;
    link_state_t state;
    phase_t      phase;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic        rw, gcall, nvUsed, sdaOe, reload, nvBusy;
    logic [5:0]  ptr;
    logic [7:0]  hiByte;
    chan_bank_t  inReg, outReg;
    nv_bank_t    nvm;
    logic [17:0] nvProg;
    logic [4:0]  nvWrites;
    logic [3:0]  writeCode;
    logic [14:0] busyCnt;
  } core_state_t;
endpackage

// ===== rtl/gamma_dac_register_access.sv
// serial slave command decoder for the gamma/common-voltage channel registers
`timescale 1ns/1ps
`include "gamma_dac_consts.svh"
module gamma_dac_register_access #(
  parameter int unsigned NV_PROG_CYCLES = `NV_PROG_CYCLES
) (
  input  wire logic                      core_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clkEn,
  input  wire logic                      sclIn,
  input  wire logic                      sdaIn,
  output logic                           sdaOut,
  output logic                           sdaOe,
  input  wire logic                      addrSel,
  output gamma_dac_pkg::chan_bank_t      chanOut,
  output logic                           nvBusy
);
  // ==========================================================
  // helper functions
  function automatic logic [14:0] eccEnc(input logic [9:0] data);
    logic [14:0] c;
    logic [3:0]  k;
    c = '0;
    k = 4'h0;
    for (int i = 1; i < 15; i++)
      if (i != 1 && i != 2 && i != 4 && i != 8)
      begin
        c[i] = data[k];
        k = k + 4'h1;
      end
    for (int p = 0; p < 4; p++)
      for (int i = 3; i < 15; i++)
        if (i[p] && i != (1 << p)) c[1 << p] = c[1 << p] ^ c[i];
    c[0] = ^c[14:1];
    return c;
  endfunction

  // hamming with overall parity: one flip corrected, two flagged
  function automatic gamma_dac_pkg::ecc_result_t eccDec(input logic [14:0] word);
    gamma_dac_pkg::ecc_result_t r;
    logic [14:0] c;
    logic [3:0]  s;
    logic [3:0]  k;
    c = word;
    s = 4'h0;
    k = 4'h0;
    r = '0;
    for (int i = 1; i < 15; i++)
      if (c[i]) s = s ^ 4'(i);
    r.ok = 1'b1;
    if (^c)
    begin
      if (s == 4'hf) r.ok = 1'b0;
      else c[s] = ~c[s];
    end
    else if (s != 4'h0) r.ok = 1'b0;
    for (int i = 1; i < 15; i++)
      if (i != 1 && i != 2 && i != 4 && i != 8)
      begin
        r.data[k] = c[i];
        k = k + 4'h1;
      end
    return r;
  endfunction

  // value that a fetch of one stored word puts into a channel
  function automatic logic [9:0] fetchWord(input logic [14:0] word, input logic prog);
    gamma_dac_pkg::ecc_result_t r;
    r = eccDec(word);
    return (prog && r.ok) ? r.data : `DEFAULT_CODE;
  endfunction

  // {valid, index} of the channel behind a pointer
  function automatic logic [5:0] chanOf(input logic [5:0] ptr);
    if (ptr <= `PTR_GAMMA_LAST) return {1'b1, ptr[4:0]};
    if (ptr == `PTR_COM_FIRST) return 6'h30;
    if (ptr == `PTR_COM_SECOND) return 6'h31;
    return 6'h00;
  endfunction

  function automatic logic [15:0] regRead(input logic [5:0] ptr, input logic [9:0] chanVal,
                                          input logic [3:0] code);
    logic [5:0] ch;
    ch = chanOf(ptr);
    if (ch[5]) return {6'h00, chanVal};
    case (ptr)
      `PTR_REVISION:    return `REVISION_CODE;
      `PTR_IDENTITY:    return `IDENTITY_CODE;
      `PTR_WRITE_COUNT: return {12'h000, code};
      default:          return 16'h0000;
    endcase
  endfunction

  // ==========================================================
  // state and next state
  gamma_dac_pkg::core_state_t q, d;
  logic        start, stop, sclRise, sclFall, loadTx, nvWriteEv, volWriteEv;
  logic [5:0]  ch;
  logic [5:0]  acqCh;
  logic [4:0]  chIdx;
  logic [9:0]  wordVal;
  logic [15:0] rdWord;

  // only synchronised copies feed the edge and condition detectors
  assign sclRise = q.sclSync && !q.sclPrev;
  assign sclFall = !q.sclSync && q.sclPrev;
  assign start   = q.sclSync && q.sclPrev && !q.sdaSync && q.sdaPrev;
  assign stop    = q.sclSync && q.sclPrev && q.sdaSync && !q.sdaPrev;
  assign ch      = chanOf(q.ptr);
  assign chIdx   = ch[4:0];
  assign acqCh   = chanOf(q.shift[5:0]); // channel named by a single acquire
  assign wordVal = {q.hiByte[1:0], q.shift};
  assign rdWord  = regRead(q.ptr, q.inReg[chIdx], q.writeCode);

  always_comb
  begin
    d = q;
    loadTx = 1'b0;
    nvWriteEv = 1'b0;
    volWriteEv = 1'b0;
    if (clkEn)
    begin
      d.sclMeta = sclIn;
      d.sclSync = q.sclMeta;
      d.sclPrev = q.sclSync;
      d.sdaMeta = sdaIn;
      d.sdaSync = q.sdaMeta;
      d.sdaPrev = q.sdaSync;
      d.selMeta = addrSel;
      d.selSync = q.selMeta;
      if (q.busyCnt != 15'h0000) d.busyCnt = q.busyCnt - 15'h0001;
      d.nvBusy = (q.busyCnt > 15'h0001);
      // general acquire and general-call reset both fetch every stored word
      if (q.reload)
      begin
        d.reload = 1'b0;
        for (int i = 0; i < `NUM_CHAN; i++)
        begin
          d.inReg[i] = fetchWord(q.nvm[i], q.nvProg[i]);
          d.outReg[i] = d.inReg[i];
        end
      end
      if (stop)
      begin
        d.state = gamma_dac_pkg::ST_IDLE;
        d.sdaOe = 1'b0;
      end
      else if (start)
      begin
        d.state = gamma_dac_pkg::ST_RX;
        d.phase = gamma_dac_pkg::PH_ADDR;
        d.bitCnt = 4'h0;
        d.sdaOe = 1'b0;
      end
      else
        case (q.state)
          gamma_dac_pkg::ST_RX:
          begin
            if (sclRise)
            begin
              d.shift = {q.shift[6:0], q.sdaSync};
              d.bitCnt = q.bitCnt + 4'h1;
            end
            else if (sclFall && q.bitCnt == 4'h8)
            begin
              d.state = gamma_dac_pkg::ST_ACK;
              d.sdaOe = 1'b1;
              case (q.phase)
                gamma_dac_pkg::PH_ADDR:
                begin
                  d.rw = q.shift[0];
                  d.gcall = (q.shift == `GCALL_ADDR);
                  d.phase = q.shift[0] ? gamma_dac_pkg::PH_DHI : gamma_dac_pkg::PH_PTR;
                  if (q.shift[7:1] != {`DEV_ADDR_HI, q.selSync} && q.shift != `GCALL_ADDR)
                  begin
                    d.state = gamma_dac_pkg::ST_IDLE;
                    d.sdaOe = 1'b0;
                  end
                end
                gamma_dac_pkg::PH_PTR:
                begin
                  d.phase = gamma_dac_pkg::PH_DHI;
                  d.ptr = q.shift[5:0];
                  d.nvUsed = 1'b0;
                  if (q.gcall)
                  begin
                    d.reload = (q.shift == `GCALL_RESET);
                    d.state = d.reload ? gamma_dac_pkg::ST_ACK : gamma_dac_pkg::ST_IDLE;
                  end
                  else if (q.shift[7:6] == `CMD_PLAIN)
                  begin
                    if (q.shift[5:0] > `PTR_LAST_CHAN && q.shift[5:0] < `PTR_REVISION)
                      d.state = gamma_dac_pkg::ST_IDLE;
                  end
                  else if (q.shift[7:6] != 2'h3 && q.shift[5:0] <= `PTR_LAST_CHAN)
                  begin
                    d.writeCode = (q.nvWrites == 5'h00) ? 4'h0 : 4'(q.nvWrites - 5'h01);
                    if (q.shift[7:6] == `CMD_GEN_ACQ) d.reload = 1'b1;
                    else if (acqCh[5])
                    begin
                      d.inReg[acqCh[4:0]] = fetchWord(q.nvm[acqCh[4:0]], q.nvProg[acqCh[4:0]]);
                      d.outReg[acqCh[4:0]] = d.inReg[acqCh[4:0]];
                    end
                  end
                  else d.state = gamma_dac_pkg::ST_IDLE;
                  if (d.state == gamma_dac_pkg::ST_IDLE) d.sdaOe = 1'b0;
                end
                gamma_dac_pkg::PH_DHI:
                begin
                  d.hiByte = q.shift;
                  d.phase = gamma_dac_pkg::PH_DLO;
                end
                default:
                begin
                  d.phase = gamma_dac_pkg::PH_DHI;
                  if (q.hiByte[7:6] == `DATA_NV_MARK)
                  begin
                    if (!q.nvUsed && ch[5])
                    begin
                      nvWriteEv = 1'b1;
                      d.nvUsed = 1'b1;
                      d.nvm[chIdx] = eccEnc(wordVal);
                      d.nvProg[chIdx] = 1'b1;
                      d.inReg[chIdx] = wordVal;
                      d.outReg[chIdx] = wordVal;
                      d.busyCnt = 15'(NV_PROG_CYCLES);
                      d.nvBusy = 1'b1;
                      if (q.nvWrites != `NV_WRITE_SAT) d.nvWrites = q.nvWrites + 5'h01;
                    end
                  end
                  else
                  begin
                    volWriteEv = 1'b1;
                    if (ch[5]) d.inReg[chIdx] = wordVal;
                    if (q.hiByte[7]) d.outReg = d.inReg;
                    d.ptr = q.ptr + 6'h01;
                  end
                end
              endcase
            end
          end
          gamma_dac_pkg::ST_ACK:
            if (sclFall)
            begin
              d.sdaOe = 1'b0;
              d.bitCnt = 4'h0;
              if (q.rw) loadTx = 1'b1;
              else d.state = gamma_dac_pkg::ST_RX;
            end
          gamma_dac_pkg::ST_TX:
            if (sclFall)
            begin
              if (q.bitCnt == 4'h8)
              begin
                d.sdaOe = 1'b0;
                d.state = gamma_dac_pkg::ST_RACK;
              end
              else
              begin
                d.shift = {q.shift[6:0], 1'b0};
                d.sdaOe = !q.shift[6];
                d.bitCnt = q.bitCnt + 4'h1;
              end
            end
          gamma_dac_pkg::ST_RACK:
            if (sclRise)
            begin
              if (q.sdaSync) d.state = gamma_dac_pkg::ST_IDLE;
              else d.bitCnt = 4'h9;
            end
            else if (sclFall && q.bitCnt == 4'h9) loadTx = 1'b1;
          default: d.state = gamma_dac_pkg::ST_IDLE;
        endcase
      // first bit of the next byte goes out on the same falling edge
      if (loadTx)
      begin
        d.state = gamma_dac_pkg::ST_TX;
        d.bitCnt = 4'h1;
        d.shift = (q.phase == gamma_dac_pkg::PH_DHI) ? rdWord[15:8] : rdWord[7:0];
        d.sdaOe = !d.shift[7];
        d.phase = (q.phase == gamma_dac_pkg::PH_DHI) ? gamma_dac_pkg::PH_DLO
                                                      : gamma_dac_pkg::PH_DHI;
        if (q.phase != gamma_dac_pkg::PH_DHI) d.ptr = q.ptr + 6'h01;
      end
    end
  end

  // ==========================================================
  // registers; reset models a fresh part with blank stored words
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.inReg <= {`NUM_CHAN{`DEFAULT_CODE}};
      q.outReg <= {`NUM_CHAN{`DEFAULT_CODE}};
    end
    else q <= d;
  end

  assign sdaOut  = 1'b0; // open drain: only ever pulls low
  assign sdaOe   = q.sdaOe;
  assign chanOut = q.outReg;
  assign nvBusy  = q.nvBusy;

  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_ecc_single_fix: assert property (eccDec(eccEnc(wordVal) ^ (15'h0001 << q.bitCnt)).data == wordVal)
    else $error("single stored bit not corrected");
  a_ecc_double_flag: assert property (q.bitCnt == 4'h0 || !eccDec(eccEnc(wordVal) ^ 15'h0001 ^ (15'h0001 << q.bitCnt)).ok)
    else $error("double stored error not flagged");
  a_nv_loads_out: assert property (clkEn && nvWriteEv |=> q.outReg[$past(chIdx)] == $past(wordVal) && nvBusy)
    else $error("stored write did not load output");
  a_busy_holds: assert property ($rose(nvBusy) |-> nvBusy [*8])
    else $error("programming busy dropped early");
  a_bit15_copy: assert property (clkEn && volWriteEv && q.hiByte[7] && !q.reload |=> q.outReg == q.inReg)
    else $error("bit 15 did not transfer inputs");
  a_ident_read: assert property (clkEn && loadTx && q.phase == gamma_dac_pkg::PH_DHI && q.ptr == `PTR_IDENTITY |=> q.shift == `IDENTITY_CODE >> 8)
    else $error("identity high byte wrong");
  a_hole_zero: assert property (clkEn && loadTx && q.ptr == 6'h10 |=> q.shift == 8'h00)
    else $error("unimplemented address not zero");
  a_stop_keeps: assert property (clkEn && stop && q.phase == gamma_dac_pkg::PH_DLO && !q.reload |=> q.inReg == $past(q.inReg) && q.state == gamma_dac_pkg::ST_IDLE)
    else $error("partial word changed register");
  a_ack_driven: assert property (q.state == gamma_dac_pkg::ST_ACK |-> sdaOe)
    else $error("acknowledge not driven");
endmodule // gamma_dac_register_access

// ===== tb/serial_master_model.sv
// behavioural two-wire bus master that drives the block's serial pins
`timescale 1ns/1ps
module serial_master_model (
  output logic      sclLine,
  output logic      sdaDrive,
  input  wire logic sdaLine
);
  // quarter of the 160 ns link period
  localparam time Q = 40ns;

  // ============================================================
  // idle bus: clock stands high, data released to the pull-up
  initial
  begin
    sclLine = 1'b1;
    sdaDrive = 1'b1;
  end

  // start or repeated start: data falls while the clock is high
  task automatic frameStart;
    sdaDrive = 1'b1;
    #Q;
    sclLine = 1'b1;
    #Q;
    sdaDrive = 1'b0;
    #Q;
    sclLine = 1'b0;
    #Q;
  endtask

  // stop leaves the clock parked high between frames
  task automatic frameStop;
    sdaDrive = 1'b0;
    #Q;
    sclLine = 1'b1;
    #Q;
    sdaDrive = 1'b1;
    #Q;
  endtask

  // msb first; data changes only while the clock is low
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaDrive = b[i];
      #Q;
      sclLine = 1'b1;
      #(2 * Q);
      sclLine = 0;
      #Q;
    end
    sdaDrive = 1'b1;
    #Q;
    sclLine = 1'b1;
    #Q;
    ack = ~sdaLine;
    #Q;
    sclLine = 1'b0;
    #Q;
  endtask

  // acks each byte except the last, which it leaves unacknowledged
  task automatic getByte(input logic lastByte, output logic [7:0] b);
    sdaDrive = 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      #Q;
      sclLine = 1'b1;
      #Q;
      b[i] = sdaLine;
      #Q;
      sclLine = 1'b0;
      #Q;
    end
    sdaDrive = lastByte;
    #Q;
    sclLine = 1'b1;
    #(2 * Q);
    sclLine = 1'b0;
    #Q;
    sdaDrive = 1'b1;
  endtask
endmodule // serial_master_model

// ===== tb/tb.sv
// self-checking bench for the gamma/common-voltage register access block
`timescale 1ns/1ps
`include "gamma_dac_consts.svh"
module tb;
  localparam logic [7:0] ADDR_W = {`DEV_ADDR_HI, 1'b0, 1'b0};
  localparam logic [7:0] ADDR_R = {`DEV_ADDR_HI, 1'b0, 1'b1};
  logic                      coreClk = 1'b0;
  logic                      sysRst = 1'b1;
  logic                      clkEn = 1'b1;
  logic                      addrSel = 1'b0;
  logic                      scl;
  logic                      sdaDrive;
  logic                      sdaOe;
  logic                      sdaOut;
  logic                      nvBusy;
  gamma_dac_pkg::chan_bank_t chanOut;
  int                        errCount = 0;
  int                        totalChecks = 0;
  int                        busyCycles = 0;
  // open-drain data line with pull-up: low whenever the device pulls
  wire                       sdaLine = (sdaOe === 1'b1) ? 1'b0 : sdaDrive;

  // ============================================================
  // clock, instances and busy monitor
  always #5 coreClk = ~coreClk;
  always @(posedge coreClk)
    if (nvBusy === 1'b1)
      busyCycles++;

  gamma_dac_register_access #(.NV_PROG_CYCLES(20)) gamma_dac_register_access_inst (
    .core_clk(coreClk), .sys_rst(sysRst), .clkEn(clkEn), .sclIn(scl), .sdaIn(sdaLine),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(addrSel), .chanOut(chanOut), .nvBusy(nvBusy));
  serial_master_model serial_master_model_inst (
    .sclLine(scl), .sdaDrive(sdaDrive), .sdaLine(sdaLine));

  // ============================================================
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errCount++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tallyAndFinish;
    if (errCount == 0 && totalChecks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chan(input int i, input logic [9:0] exp);
    check("chanOut", {6'h0, chanOut[i]}, {6'h0, exp});
  endtask

  // one framed write; every byte acked except possibly the last
  task automatic txn(input logic [7:0] bytes[$], input logic lastAck);
    logic ack;
    serial_master_model_inst.frameStart();
    foreach (bytes[i])
    begin
      serial_master_model_inst.sendByte(bytes[i], ack);
      check("ack", {15'h0, ack}, {15'h0, (i == bytes.size() - 1) ? lastAck : 1'b1});
    end
    serial_master_model_inst.frameStop();
  endtask

  // pointer write, repeated start, then n words high byte first
  task automatic rd(input logic [7:0] ptr, input int n, output logic [15:0] w[$]);
    logic a1, a2, a3;
    logic [7:0] hi, lo;
    w = {};
    serial_master_model_inst.frameStart();
    serial_master_model_inst.sendByte(ADDR_W, a1);
    serial_master_model_inst.sendByte(ptr, a2);
    serial_master_model_inst.frameStart();
    serial_master_model_inst.sendByte(ADDR_R, a3);
    check("readAck", {15'h0, a1 & a2 & a3}, 16'h1);
    for (int k = 0; k < n; k++)
    begin
      serial_master_model_inst.getByte(1'b0, hi);
      serial_master_model_inst.getByte(k == n - 1, lo);
      w.push_back({hi, lo});
    end
    serial_master_model_inst.frameStop();
  endtask

  // ============================================================
  // hang guard
  initial
  begin
    #900us;
    errCount++;
    tallyAndFinish();
  end

  // ============================================================
  // main sequence
  initial
  begin
    logic [15:0] w[$];
    repeat (3) @(posedge coreClk);
    #1 sysRst = 1'b0;
    repeat (4) @(posedge coreClk);
    for (int i = 0; i < 18; i++)
      chan(i, `DEFAULT_CODE);
    rd(8'h3d, 1, w);
    check("identity", w[0], `IDENTITY_CODE);
    rd(8'h3c, 1, w);
    check("revision", w[0], `REVISION_CODE);
    // burst write crossing the two discarded sets into the common pair
    txn('{ADDR_W, 8'h0e, 8'h81, 8'h11, 8'h82, 8'h22, 8'h83, 8'h33, 8'h83, 8'h33,
          8'h80, 8'h44, 8'h83, 8'hff}, 1'b1);
    chan(14, 10'h111);
    chan(15, 10'h222);
    chan(16, 10'h044);
    chan(17, 10'h3ff);
    rd(8'h0f, 4, w);
    check("burst0", w[0], 16'h0222);
    check("hole0", w[1], 16'h0000);
    check("hole1", w[2], 16'h0000);
    check("burst3", w[3], 16'h0044);
    // a lone high byte before stop must not land
    txn('{ADDR_W, 8'h0e, 8'h80, 8'h55, 8'h81}, 1'b1);
    chan(14, 10'h055);
    chan(15, 10'h222);
    // bit 15 clear holds the output, a later set copies every input
    txn('{ADDR_W, 8'h00, 8'h01, 8'h23}, 1'b1);
    chan(0, `DEFAULT_CODE);
    rd(8'h00, 1, w);
    check("inReg0", w[0], 16'h0123);
    txn('{ADDR_W, 8'h01, 8'h80, 8'h07}, 1'b1);
    chan(0, 10'h123);
    chan(1, 10'h007);
    // stored write, then a second stored word that must be dropped
    txn('{ADDR_W, 8'h03, 8'h42, 8'h9a, 8'h41, 8'h11}, 1'b1);
    chan(3, 10'h29a);
    check("busyLen", {15'h0, busyCycles >= 20 && busyCycles <= 22}, 16'h1);
    check("nvBusy", {15'h0, nvBusy}, 16'h0);
    txn('{ADDR_W, 8'h03, 8'h80, 8'h00}, 1'b1);
    chan(3, 10'h000);
    txn('{ADDR_W, 8'h43}, 1'b1);
    chan(3, 10'h29a);
    txn('{ADDR_W, 8'h03, 8'h80, 8'h00}, 1'b1);
    txn('{ADDR_W, 8'h80}, 1'b1);
    chan(3, 10'h29a);
    chan(4, `DEFAULT_CODE);
    chan(0, `DEFAULT_CODE);
    rd(8'h3f, 1, w);
    check("writeCount", w[0], 16'h0000);
    // refused pointers, foreign address and a bad general-call byte
    txn('{ADDR_W, 8'hc0}, 1'b0);
    txn('{ADDR_W, 8'h18}, 1'b0);
    txn('{ADDR_W, 8'h58}, 1'b0);
    txn('{8'h5a}, 1'b0);
    txn('{8'h00, 8'h07}, 1'b0);
    // general-call reset reloads every channel from the stored words
    txn('{ADDR_W, 8'h01, 8'h80, 8'h3c}, 1'b1);
    txn('{8'h00, 8'h06}, 1'b1);
    chan(1, `DEFAULT_CODE);
    chan(3, 10'h29a);
    // clock enable low freezes the block: an address goes unanswered
    @(posedge coreClk);
    #1 clkEn = 1'b0;
    txn('{ADDR_W}, 1'b0);
    chan(3, 10'h29a);
    @(posedge coreClk);
    #1 clkEn = 1'b1;
    txn('{ADDR_W, 8'h02, 8'h80, 8'h99}, 1'b1);
    chan(2, 10'h099);
    tallyAndFinish();
  end
endmodule // tb
